// *** inc/adsr_consts.vh ***
// Purpose: shared constants of the serial data-ready block
// Assumes: included by bare name from rtl files
// Notes: counts are in link clock edges unless named otherwise
`ifndef ADSR_CONSTS_VH
`define ADSR_CONSTS_VH

// width of one conversion result
`define ADSR_DATA_W 16
// read-result command byte sent by the host
`define ADSR_CMD_READ_RESULT 8'hC3
// width of a command byte
`define ADSR_CMD_W 8
// extra clocks after a data read that park the line high
`define ADSR_TAIL_CLKS 5'h10
// index of the last bit of a 16-edge phase
`define ADSR_LAST_EDGE 5'h0F
// index of the last command bit
`define ADSR_LAST_CMD_BIT 4'h7
// reset values of the sampled pins: chip select, serial clock, data in
`define ADSR_PIN_RST 3'h1

// one-hot frame states
`define ADSR_ST_IDLE 4'h1
`define ADSR_ST_SHIFT 4'h2
`define ADSR_ST_TAIL 4'h4
`define ADSR_ST_READY 4'h8

`endif

// *** rtl/adsr_sync3.v ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: input is asynchronous to MCLK
// Notes: level changes only once the second and third stages agree
`default_nettype none

module adsr_sync3 #(
    parameter RST_VAL = 1'b0
) (
    // clock and reset
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    // pin and filtered level
    input wire PIN,
    output reg LEVEL
);

    reg s1_ff; // first stage, only read by s2_ff
    reg s2_ff; // second stage
    reg s3_ff; // third stage

    // shift chain and filter; a single-cycle glitch never reaches the level
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s1_ff <= RST_VAL;
            s2_ff <= RST_VAL;
            s3_ff <= RST_VAL;
            LEVEL <= RST_VAL;
        end else if (CE) begin
            s1_ff <= PIN;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                LEVEL <= s3_ff; // stages agree: accept
            end
        end
    end

endmodule // adsr_sync3

`default_nettype wire

// *** rtl/adsr_ready_link.v ***
// Purpose: data-ready signalling and result read-out on a mode-1 serial link
// Assumes: MCLK at 200 MHz, far faster than the serial clock
// Notes: serial pins are sampled, so link timing is quantised to MCLK
`include "adsr_consts.vh"
`default_nettype none

module adsr_ready_link (
    // clock, reset, enable
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    // serial link pins
    input wire CS_N,
    input wire SCLK,
    input wire DIN,
    output reg SERIAL_OUT_WITH_READY_O,
    output reg SERIAL_OUT_WITH_READY_OE_N,
    output reg CONVERSION_DONE_PIN_N,
    // converter side
    input wire CONV_STROBE,
    input wire [`ADSR_DATA_W-1:0] CONV_RESULT,
    input wire READY_SIGNAL_SELECT,
    input wire TEMP_SENSOR_SELECT,
    output reg TEMP_SENSOR_MODE
);

    wire [2:0] pin_raw; // cs, sclk, din as they arrive
    wire [2:0] pin_lvl; // filtered levels
    wire cs_lvl; // filtered chip select, high = deselected
    wire sclk_lvl; // filtered serial clock
    wire din_lvl; // filtered data in
    // idle levels per pin: cs high, sclk and din low; one bit per synchroniser
    localparam [2:0] PIN_RST_ALL = `ADSR_PIN_RST;

    reg cs_prev_ff; // chip select one cycle back
    reg sclk_prev_ff; // serial clock one cycle back
    reg [3:0] state_ff; // one-hot frame state
    reg [3:0] nxt_state;
    reg [4:0] cnt_ff; // rising edges within a phase
    reg [4:0] nxt_cnt;
    reg [3:0] fcnt_ff; // command bits taken this frame
    reg [3:0] nxt_fcnt;
    reg [`ADSR_CMD_W-1:0] cmd_ff; // command shift register
    reg [`ADSR_CMD_W-1:0] nxt_cmd;
    reg [`ADSR_DATA_W-1:0] latest_ff; // latest valid result
    reg [`ADSR_DATA_W-1:0] nxt_latest;
    reg [`ADSR_DATA_W-1:0] sh_ff; // frozen copy being shifted out
    reg [`ADSR_DATA_W-1:0] nxt_sh;
    reg new_ff; // unread result waiting
    reg nxt_new;
    reg bit_ff; // data bit currently presented
    reg nxt_bit;
    reg pres_ff; // line shows bit_ff rather than readiness
    reg nxt_pres;
    reg read_done; // a full result was clocked out
    reg ready_lvl; // level shown when not presenting data
    reg nxt_out;
    reg nxt_oe_n;
    reg sclk_rise;
    reg sclk_fall;
    reg cs_fall;
    reg [`ADSR_CMD_W-1:0] cmd_next; // command byte incl. the bit now sampled

    assign pin_raw = {DIN, SCLK, CS_N};
    assign cs_lvl = pin_lvl[0];
    assign sclk_lvl = pin_lvl[1];
    assign din_lvl = pin_lvl[2];

    // every pin from the host crosses into MCLK through the same filter
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            adsr_sync3 #(
                .RST_VAL(PIN_RST_ALL[gi])
            ) u_sync (
                .MCLK(MCLK),
                .RSTN(RSTN),
                .CE(CE),
                .PIN(pin_raw[gi]),
                .LEVEL(pin_lvl[gi])
            );
        end
    endgenerate

    // next-state logic for the frame, the flags and the line
    always @* begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_fcnt = fcnt_ff;
        nxt_cmd = cmd_ff;
        nxt_sh = sh_ff;
        nxt_bit = bit_ff;
        nxt_pres = pres_ff;
        read_done = 1'b0;
        // edges of the filtered link signals; clock idles low
        sclk_rise = sclk_lvl & ~sclk_prev_ff;
        sclk_fall = ~sclk_lvl & sclk_prev_ff;
        cs_fall = ~cs_lvl & cs_prev_ff;
        cmd_next = {cmd_ff[`ADSR_CMD_W-2:0], din_lvl};
        // a new result replaces the stored one, and the frozen copy only at a read-result restart in the same cycle
        nxt_latest = CONV_STROBE ? CONV_RESULT : latest_ff;

        if (cs_lvl) begin
            // deselected: frame aborted, nothing shifts
            nxt_state = `ADSR_ST_IDLE;
            nxt_pres = 1'b0;
        end else if (cs_fall) begin
            // new frame: freeze the result so a conversion cannot tear it
            nxt_state = `ADSR_ST_SHIFT;
            nxt_sh = latest_ff;
            nxt_cnt = 5'h00;
            nxt_fcnt = 4'h0;
            nxt_cmd = {`ADSR_CMD_W{1'b0}};
            nxt_pres = 1'b0;
        end else begin
            if (sclk_rise) begin
                // data launched on rising edges
                case (state_ff)
                    `ADSR_ST_SHIFT: begin
                        nxt_bit = sh_ff[`ADSR_DATA_W-1];
                        nxt_sh = {sh_ff[`ADSR_DATA_W-2:0], 1'b0};
                        nxt_pres = 1'b1;
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == `ADSR_LAST_EDGE) begin
                            read_done = 1'b1; // last bit now on the line
                            nxt_state = `ADSR_ST_TAIL;
                            nxt_cnt = 5'h00;
                        end
                    end
                    `ADSR_ST_TAIL: begin
                        // extra clocks hold the line high
                        nxt_bit = 1'b1;
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == `ADSR_TAIL_CLKS - 5'h01) begin
                            nxt_state = `ADSR_ST_READY;
                            nxt_pres = 1'b0;
                        end
                    end
                    default: begin
                        // ready or idle: further clocks change nothing
                        nxt_bit = bit_ff;
                    end
                endcase
            end
            if (sclk_fall && (fcnt_ff <= `ADSR_LAST_CMD_BIT)) begin
                // host data sampled on falling edges, first byte only
                nxt_cmd = cmd_next;
                nxt_fcnt = fcnt_ff + 4'h1;
                if ((fcnt_ff == `ADSR_LAST_CMD_BIT) && (cmd_next == `ADSR_CMD_READ_RESULT)) begin
                    // read-result: restart with the latest result once the eighth command bit is in
                    nxt_state = `ADSR_ST_SHIFT;
                    nxt_sh = nxt_latest;
                    nxt_cnt = 5'h00;
                end
            end
        end

        // unread flag: a new conversion wins over the read that clears it
        nxt_new = new_ff;
        if (read_done) begin
            nxt_new = 1'b0;
        end
        if (CONV_STROBE) begin
            nxt_new = 1'b1;
        end

        // readiness on the line only when the select bit is 1
        if (READY_SIGNAL_SELECT) begin
            ready_lvl = ~nxt_new; // low = unread result, high = none
        end else begin
            ready_lvl = 1'b1;
        end
        // at select the level is driven at once, no clock needed
        nxt_out = nxt_pres ? nxt_bit : ready_lvl;
        // deselected: line released whatever the select bit
        nxt_oe_n = cs_lvl;
    end

    // state registers; CE low freezes everything
    always @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            cs_prev_ff <= 1'b1;
            sclk_prev_ff <= 1'b0;
            state_ff <= `ADSR_ST_IDLE;
            cnt_ff <= 5'h00;
            fcnt_ff <= 4'h0;
            cmd_ff <= {`ADSR_CMD_W{1'b0}};
            latest_ff <= {`ADSR_DATA_W{1'b0}};
            sh_ff <= {`ADSR_DATA_W{1'b0}};
            new_ff <= 1'b0;
            bit_ff <= 1'b1;
            pres_ff <= 1'b0;
            SERIAL_OUT_WITH_READY_O <= 1'b1;
            SERIAL_OUT_WITH_READY_OE_N <= 1'b1;
            CONVERSION_DONE_PIN_N <= 1'b1;
            TEMP_SENSOR_MODE <= 1'b0;
        end else if (CE) begin
            cs_prev_ff <= cs_lvl;
            sclk_prev_ff <= sclk_lvl;
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            fcnt_ff <= nxt_fcnt;
            cmd_ff <= nxt_cmd;
            latest_ff <= nxt_latest;
            sh_ff <= nxt_sh;
            new_ff <= nxt_new;
            bit_ff <= nxt_bit;
            pres_ff <= nxt_pres;
            SERIAL_OUT_WITH_READY_O <= nxt_out;
            SERIAL_OUT_WITH_READY_OE_N <= nxt_oe_n;
            // dedicated pin follows the flag regardless of chip select
            CONVERSION_DONE_PIN_N <= ~nxt_new;
            // converter source select; compensation is left to the host
            TEMP_SENSOR_MODE <= TEMP_SENSOR_SELECT;
        end
    end

endmodule // adsr_ready_link

`default_nettype wire

// *** dv/adsr_checker.sv ***
// Purpose: port checker for adsr_ready_link
// Assumes: CE held high, select pins steady around frames
// Notes: pin edges reach the logic about 5 MCLK late
`default_nettype none
module adsr_chk (
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // link side
    input wire logic CS_N,
    input wire logic SERIAL_OUT_WITH_READY_O,
    input wire logic SERIAL_OUT_WITH_READY_OE_N,
    input wire logic CONVERSION_DONE_PIN_N,
    // converter side
    input wire logic CONV_STROBE,
    input wire logic READY_SIGNAL_SELECT,
    input wire logic TEMP_SENSOR_SELECT,
    input wire logic TEMP_SENSOR_MODE
);
    timeunit 1ns;
    timeprecision 100ps;
    // short aliases keep each property on a few lines
    wire o = SERIAL_OUT_WITH_READY_O;
    wire oe_n = SERIAL_OUT_WITH_READY_OE_N;
    wire dn = CONVERSION_DONE_PIN_N;
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RSTN);
    AST_DONE_SET: assert property (CONV_STROBE |=> !dn)
        else $error("done pin not set by strobe");
    AST_DONE_CAUSE: assert property ($fell(dn) |-> $past(CONV_STROBE))
        else $error("done pin fell without strobe");
    AST_DONE_HOLD: assert property (CS_N [*6] ##0 !dn |=> !dn)
        else $error("done pin cleared while deselected");
    AST_CLR_IN_FRAME: assert property ($rose(dn) |-> !oe_n)
        else $error("done pin cleared outside a frame");
    AST_HIGHZ: assert property (CS_N [*7] |-> oe_n)
        else $error("line driven while deselected");
    AST_DRIVE: assert property (!CS_N [*7] |-> !oe_n)
        else $error("line not driven while selected");
    AST_POLL: assert property ($fell(oe_n) && READY_SIGNAL_SELECT |-> o == dn)
        else $error("poll level differs from done pin");
    AST_SEL_OFF: assert property ($fell(oe_n) && !READY_SIGNAL_SELECT |-> o)
        else $error("readiness shown on line with select 0");
    AST_TEMP: assert property ($stable(TEMP_SENSOR_SELECT) [*2] |->
        TEMP_SENSOR_MODE == TEMP_SENSOR_SELECT)
        else $error("temperature mode not following select");
    // main scenarios reached
    COV_POLL: cover property ($fell(oe_n) && READY_SIGNAL_SELECT && !o);
    COV_CLR: cover property ($rose(dn));
    COV_STROBE: cover property (CONV_STROBE);
endmodule // adsr_chk
bind adsr_ready_link adsr_chk u_chk (.MCLK, .RSTN, .CS_N, .SERIAL_OUT_WITH_READY_O,
    .SERIAL_OUT_WITH_READY_OE_N, .CONVERSION_DONE_PIN_N, .CONV_STROBE,
    .READY_SIGNAL_SELECT, .TEMP_SENSOR_SELECT, .TEMP_SENSOR_MODE);
`default_nettype wire

// *** dv/adsr_host.sv ***
// Purpose: host master model driving the mode-1 serial link
// Assumes: called hierarchically by the bench, one frame at a time
// Notes: clock stands low outside frames
`default_nettype none
module adsr_host #(
    parameter int HALF = 32
) (
    // link pins toward the device
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic sdo,
    input wire logic sdo_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // a released line reads inverted so a stale value cannot pass
    wire line = sdo_oe_n ? ~sdo : sdo;
    // idle pins: deselected, clock low
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din = 1'b0;
    end
    // one frame: poll level, then nclk clocks with cmd on the first 8
    task automatic frame(input logic [7:0] cmd, input int nclk,
                         output logic poll, output logic [47:0] rx);
        rx = '0;
        cs_n = 1'b0;
        #100 poll = line;
        for (int i = 0; i < nclk; i++) begin
            sclk = 1'b1;
            din = (i < 8) ? cmd[7 - i] : 1'b0;
            #HALF sclk = 1'b0;
            rx = {rx[46:0], line};
            #HALF;
        end
        #50 cs_n = 1'b1;
        #100;
    endtask
endmodule // adsr_host
`default_nettype wire

// *** dv/tb_adc_serial_data_ready_signaling.sv ***
// Purpose: self-checking bench for adsr_ready_link
// Assumes: CE tied high, host model owns the link pins
// Notes: expected words come from the strobed values
`default_nettype none
module tb_adc_serial_data_ready_signaling;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 0, rstn = 0, strobe = 0, rsel = 0, tsel = 0, poll;
    logic [15:0] res = '0;
    logic [47:0] rx;
    wire cs_n, sclk, din, o, oe_n, done_n, tsm;
    int err_count = 0, samples_checked = 0;
    initial forever #2.5 mclk = ~mclk;
    adsr_ready_link DUT (.MCLK(mclk), .RSTN(rstn), .CE(1'b1), .CS_N(cs_n), .SCLK(sclk),
        .DIN(din), .SERIAL_OUT_WITH_READY_O(o), .SERIAL_OUT_WITH_READY_OE_N(oe_n),
        .CONVERSION_DONE_PIN_N(done_n), .CONV_STROBE(strobe), .CONV_RESULT(res),
        .READY_SIGNAL_SELECT(rsel), .TEMP_SENSOR_SELECT(tsel), .TEMP_SENSOR_MODE(tsm));
    adsr_host host (.cs_n(cs_n), .sclk(sclk), .din(din), .sdo(o), .sdo_oe_n(oe_n));
    // compare any result, narrow ones zero-extended
    task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value t=%0t %s", $time, m);
        end
    endtask
    // reset values, then a result arriving while deselected
    task automatic t_idle;
        chk({oe_n, done_n, tsm}, 3'h6, "reset levels");
        @(negedge mclk) strobe = 1'b1;
        res = 16'h5A3C;
        @(negedge mclk) strobe = 1'b0;
        @(negedge mclk);
        chk(done_n, 1'b0, "done pin");
        chk(oe_n, 1'b1, "line released");
        $display("t_idle done");
    endtask
    // poll, read 16 bits plus the 16 tail clocks, poll again
    task automatic t_poll;
        rsel = 1'b1;
        host.frame(8'h00, 32, poll, rx);
        chk(poll, 1'b0, "poll with data");
        chk(rx[31:0], {16'h5A3C, 16'hFFFF}, "read and tail");
        chk(done_n, 1'b1, "done cleared");
        host.frame(8'h00, 0, poll, rx);
        chk(poll, 1'b1, "poll without data");
        $display("t_poll done");
    endtask
    // back-to-back results, then the read-result command with select 0
    task automatic t_cmd;
        @(negedge mclk) rsel = 1'b0;
        @(negedge mclk) strobe = 1'b1;
        res = 16'hA1B2;
        @(negedge mclk) res = 16'h9E61;
        @(negedge mclk) strobe = 1'b0;
        host.frame(8'hC3, 24, poll, rx);
        chk(poll, 1'b1, "select 0 level");
        chk(rx[23:0], {8'h9E, 16'h9E61}, "command read");
        $display("t_cmd done");
    endtask
    // temperature source select after input readings
    task automatic t_temp;
        @(negedge mclk) tsel = 1'b1;
        repeat (3) @(negedge mclk);
        chk(tsm, 1'b1, "temp mode on");
        tsel = 1'b0;
        repeat (3) @(negedge mclk);
        chk(tsm, 1'b0, "temp mode off");
        $display("t_temp done");
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (5) @(negedge mclk);
        rstn = 1'b1;
        repeat (5) @(negedge mclk);
        t_idle();
        t_poll();
        t_cmd();
        t_temp();
        tally_and_finish();
    end
    // hang guard
    initial begin
        #200000;
        err_count++;
        tally_and_finish();
    end
endmodule // tb_adc_serial_data_ready_signaling
`default_nettype wire
